// [byte_pick.sv]
`timescale 1ns/1ns
// ==========================================
// byte lane select, lane 0 is the least significant byte
module byte_pick (
	input wire logic [31:0] word_i,
	input wire logic [1:0] lane_i,
	output logic [7:0] byte_o
);
	// lane follows the peripheral address, not the internal address
	always_comb begin
		byte_o = word_i[8*lane_i +: 8];
	end
endmodule // byte_pick

// [fetch_if.sv]
`timescale 1ns/1ns
// ==========================================
// request and answer between control and the register-bus read engine
interface fetch_if;
	logic start;
	logic [23:0] addr;
	logic done;
	logic [31:0] data;
	logic ok;

	modport ctrl (output start, output addr, input done, input data, input ok);
	modport engine (input start, input addr, output done, output data, output ok);
endinterface

// [i2c_slave_internal_read_port.sv]
`timescale 1ns/1ns
module i2c_slave_internal_read_port (
	input wire logic mclk_i,
	input wire logic reset_i,
	// slave byte engine side
	input wire logic ptr_load_i,
	input wire logic [7:0] ptr_value_i,
	input wire logic wr_byte_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_byte_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic busy_o,
	output logic [7:0] per_ptr_o,
	// access control settings
	input wire logic read_addr_increment_en_i,
	input wire logic [1:0] read_access_size_i,
	// internal register bus, master for fetches
	output logic rbus_req_o,
	output logic [23:0] rbus_addr_o,
	input wire logic rbus_ack_i,
	input wire logic rbus_err_i,
	input wire logic [31:0] rbus_data_i,
	// internal register bus, read port onto this block
	input wire logic host_rd_i,
	input wire logic [19:0] host_addr_i,
	output logic [31:0] host_rd_data_o,
	output logic host_rd_valid_o,
	output logic access_ok_flag_o
);
	import rdport_pkg::*;

	// ==========================================
	// state
	logic [7:0] ptr_q, ptr_d;
	logic [ADDR_W-1:0] read_address_field_q, read_address_field_d;
	logic [31:0] slave_read_data_q, slave_read_data_d;
	logic access_ok_flag_q, access_ok_flag_d;
	logic pend_q, pend_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic rd_valid_q, rd_valid_d;
	logic [31:0] host_data_q, host_data_d;
	logic host_valid_q, host_valid_d;
	logic start_q, start_d;

	fetch_if fx ();

	logic [7:0] data_byte;
	logic [7:0] addr_byte;
	logic [1:0] lane;
	logic [31:0] addr_wr_word;
	// strobes as taken, and where the pointer sits
	logic take_load;
	logic take_wr;
	logic take_rd;
	logic hit_addr;
	logic hit_data;
	logic hit_stat;
	logic fetch_go;
	logic fetch_end;

	// ==========================================
	// byte lanes
	assign lane = ptr_q[1:0];

	byte_pick data_pick (
		.word_i(slave_read_data_q),
		.lane_i(lane),
		.byte_o(data_byte)
	);

	byte_pick addr_pick (
		.word_i(read_address_field_q),
		.lane_i(lane),
		.byte_o(addr_byte)
	);

	read_engine engine (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.fx(fx),
		.rbus_req_o(rbus_req_o),
		.rbus_addr_o(rbus_addr_o),
		.rbus_ack_i(rbus_ack_i),
		.rbus_err_i(rbus_err_i),
		.rbus_data_i(rbus_data_i)
	);

	// launch pulse to the engine, one cycle wide
	assign fx.start = start_q;
	// top byte kept in the register, never sent on the bus
	assign fx.addr = read_address_field_q[IADDR_W-1:0];

	// ==========================================
	// strobe decode
	// busy blocks every strobe, so a stretched byte is never overtaken
	always_comb begin
		take_load = !pend_q && ptr_load_i;
		take_wr = !pend_q && !ptr_load_i && wr_byte_i;
		take_rd = !pend_q && !ptr_load_i && !wr_byte_i && rd_byte_i;
	end

	// window hits follow the peripheral pointer only
	always_comb begin
		hit_addr = (ptr_q >= PER_ADDR_B0) && (ptr_q <= PER_ADDR_B3);
		hit_data = (ptr_q >= PER_DATA_B0) && (ptr_q <= PER_DATA_B3);
		hit_stat = (ptr_q == PER_STAT_B0);
	end

	// only the low data byte in 4-byte size goes out on the bus
	always_comb begin
		fetch_go = take_rd && (ptr_q == PER_DATA_B0) && (read_access_size_i == SIZE_4BYTE);
		fetch_end = pend_q && fx.done;
	end

	// ==========================================
	// address byte merge for slave writes
	always_comb begin
		addr_wr_word = read_address_field_q;
		addr_wr_word[8*lane +: 8] = wr_data_i;
	end

	// ==========================================
	// peripheral pointer
	always_comb begin
		ptr_d = ptr_q;
		if (fetch_end) begin
			// the fetched byte counts as the access at the low data byte
			ptr_d = ptr_q + 8'h01;
		end else if (take_load) begin
			ptr_d = ptr_value_i;
		end else if (take_wr) begin
			// writes never wrap; dropped or not, the pointer moves on
			ptr_d = ptr_q + 8'h01;
		end else if (take_rd && !fetch_go) begin
			if (ptr_q == PER_DATA_B3) begin
				ptr_d = PER_DATA_B0;
			end else begin
				ptr_d = ptr_q + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ptr_q <= 8'h00;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	// ==========================================
	// read address, written from the slave side only
	always_comb begin
		read_address_field_d = read_address_field_q;
		if (fetch_end && read_addr_increment_en_i) begin
			// step at completion, so the fetch itself used the old address
			read_address_field_d = (read_address_field_q + ADDR_STEP)
				& ADDR_ALIGN_MASK;
		end else if (take_wr && hit_addr) begin
			read_address_field_d = addr_wr_word & ADDR_ALIGN_MASK;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			read_address_field_q <= READ_ADDRESS_RST;
		end else begin
			read_address_field_q <= read_address_field_d;
		end
	end

	// ==========================================
	// fetch control
	// busy holds the byte engine, which stretches the bus clock meanwhile
	always_comb begin
		pend_d = pend_q;
		start_d = 1'b0;
		if (fetch_end) begin
			pend_d = 1'b0;
		end else if (fetch_go) begin
			pend_d = 1'b1;
			start_d = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			pend_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
			start_q <= start_d;
		end
	end

	// ==========================================
	// byte answer and data word; window writes never reach the word
	always_comb begin
		slave_read_data_d = slave_read_data_q;
		rd_data_d = rd_data_q;
		rd_valid_d = 1'b0;
		if (fetch_end) begin
			// word loaded even on a bus error; only the flag tells them apart
			slave_read_data_d = fx.data;
			rd_data_d = fx.data[7:0];
			rd_valid_d = 1'b1;
		end else if (take_rd && !fetch_go) begin
			rd_valid_d = 1'b1;
			rd_data_d = 8'h00;
			if (hit_addr) begin
				rd_data_d = addr_byte;
			end else if (hit_data) begin
				rd_data_d = data_byte;
			end else if (hit_stat) begin
				rd_data_d[ACCESS_OK_FLAG_BIT] = access_ok_flag_q;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			slave_read_data_q <= READ_DATA_RST;
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			slave_read_data_q <= slave_read_data_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	// ==========================================
	// access-ok flag, cleared only by a slave read of the status byte
	always_comb begin
		access_ok_flag_d = access_ok_flag_q;
		if (take_rd && hit_stat) begin
			access_ok_flag_d = 1'b0;
		end
		// a completing fetch in the same cycle wins over the clear
		if (fetch_end && fx.ok) begin
			access_ok_flag_d = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			access_ok_flag_q <= 1'b0;
		end else begin
			access_ok_flag_q <= access_ok_flag_d;
		end
	end

	// ==========================================
	// host read port, read-only by construction
	always_comb begin
		host_valid_d = host_rd_i;
		host_data_d = 32'h0000_0000;
		if (host_rd_i) begin
			case (host_addr_i)
				OFS_READ_ADDRESS: host_data_d = read_address_field_q;
				OFS_READ_DATA: host_data_d = slave_read_data_q;
				OFS_ACC_STATUS: host_data_d[ACCESS_OK_FLAG_BIT] = access_ok_flag_q;
				default: host_data_d = 32'h0000_0000;
			endcase
		end
	end

	// host answers never touch the flag, unlike a slave read
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			host_data_q <= 32'h0000_0000;
			host_valid_q <= 1'b0;
		end else begin
			host_data_q <= host_data_d;
			host_valid_q <= host_valid_d;
		end
	end

	// ==========================================
	// outputs straight from flops
	assign rd_data_o = rd_data_q;
	assign rd_valid_o = rd_valid_q;
	assign busy_o = pend_q;
	assign per_ptr_o = ptr_q;
	assign host_rd_data_o = host_data_q;
	assign host_rd_valid_o = host_valid_q;
	assign access_ok_flag_o = access_ok_flag_q;
endmodule // i2c_slave_internal_read_port

// [rbus_responder.sv]
`timescale 1ns/1ns
// ==========
// register bus target with a set wait
module rbus_responder (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic req_i,
	input wire logic [23:0] addr_i,
	input wire logic [3:0] lat_i,
	input wire logic err_in_i,
	output logic ack_o,
	output logic err_o,
	output logic [31:0] data_o
);
	logic [3:0] cnt_q;
	// data toggles when idle so a stale word is never mistaken for an answer
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			{ack_o, err_o, cnt_q, data_o} <= '0;
		end else if (req_i && !ack_o && cnt_q >= lat_i) begin
			ack_o <= 1'b1;
			err_o <= err_in_i;
			data_o <= {~addr_i[7:0], addr_i};
			cnt_q <= 4'h0;
		end else begin
			{ack_o, err_o} <= 2'h0;
			data_o <= ~data_o;
			cnt_q <= (req_i && !ack_o) ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule // rbus_responder

// [rdport_chk.sv]
`timescale 1ns/1ns
// ==========
// port-level checks
module rdport_chk
	import rdport_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ptr_load_i,
	input wire logic wr_byte_i,
	input wire logic rd_byte_i,
	input wire logic [1:0] read_access_size_i,
	input wire logic busy_o,
	input wire logic rd_valid_o,
	input wire logic [7:0] per_ptr_o,
	input wire logic rbus_req_o,
	input wire logic rbus_ack_i,
	input wire logic rbus_err_i,
	input wire logic host_rd_i,
	input wire logic host_rd_valid_o,
	input wire logic access_ok_flag_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// strobes the slave side really takes
	wire rd_tk = rd_byte_i && !busy_o && !ptr_load_i && !wr_byte_i;
	wire fetch = rd_tk && per_ptr_o == PER_DATA_B0 && read_access_size_i == SIZE_4BYTE;
	wire done = rbus_req_o && rbus_ack_i;
	AST_FETCH: assert property (fetch |=> busy_o ##1 rbus_req_o) else $error("no fetch");
	AST_PLAIN: assert property (rd_tk && !fetch |=> rd_valid_o) else $error("late");
	AST_NOREQ: assert property (!busy_o |-> !rbus_req_o) else $error("stray req");
	AST_WRAP: assert property (rd_tk && per_ptr_o == PER_DATA_B3 |=> per_ptr_o == 8'h14)
		else $error("no wrap");
	AST_WRSTEP: assert property (wr_byte_i && !busy_o && !ptr_load_i && per_ptr_o == 8'h17
		|=> per_ptr_o == 8'h18) else $error("write step");
	AST_HOLD: assert property (rbus_req_o && !rbus_ack_i |=> rbus_req_o) else $error("drop");
	AST_ANSWER: assert property (done |-> ##2 rd_valid_o && $fell(busy_o)) else $error("ans");
	AST_FLAG: assert property (done && !rbus_err_i |-> ##2 access_ok_flag_o) else $error("flag");
	AST_HOST: assert property (host_rd_i |=> host_rd_valid_o) else $error("host");
endmodule // rdport_chk

bind i2c_slave_internal_read_port rdport_chk u_chk (.mclk_i, .reset_i, .ptr_load_i, .wr_byte_i,
	.rd_byte_i, .read_access_size_i, .busy_o, .rd_valid_o, .per_ptr_o, .rbus_req_o, .rbus_ack_i,
	.rbus_err_i, .host_rd_i, .host_rd_valid_o, .access_ok_flag_o);

// [rdport_pkg.sv]
package rdport_pkg;

	// ==========================================
	// slave peripheral byte map
	localparam logic [7:0] PER_ADDR_B0 = 8'h10;
	localparam logic [7:0] PER_ADDR_B3 = 8'h13;
	localparam logic [7:0] PER_DATA_B0 = 8'h14;
	localparam logic [7:0] PER_DATA_B3 = 8'h17;
	localparam logic [7:0] PER_STAT_B0 = 8'h20;

	// ==========================================
	// register bus offsets of the visible registers
	localparam logic [19:0] OFS_READ_ADDRESS = 20'h1D210;
	localparam logic [19:0] OFS_READ_DATA = 20'h1D214;
	localparam logic [19:0] OFS_ACC_STATUS = 20'h1D220;

	// ==========================================
	// field layout and reset values
	localparam int ADDR_W = 32;
	localparam int IADDR_W = 24;
	localparam logic [31:0] ADDR_ALIGN_MASK = 32'hFFFF_FFFC;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	localparam logic [31:0] READ_ADDRESS_RST = 32'h0000_0000;
	localparam logic [31:0] READ_DATA_RST = 32'h0000_0000;
	localparam int ACCESS_OK_FLAG_BIT = 7;

	// read_access_size encodings
	localparam logic [1:0] SIZE_4BYTE = 2'h0;

endpackage

// [read_engine.sv]
`timescale 1ns/1ns
// ==========================================
// internal register-bus read engine
module read_engine (
	input wire logic mclk_i,
	input wire logic reset_i,
	fetch_if.engine fx,
	output logic rbus_req_o,
	output logic [23:0] rbus_addr_o,
	input wire logic rbus_ack_i,
	input wire logic rbus_err_i,
	input wire logic [31:0] rbus_data_i
);
	typedef enum logic {ENG_IDLE, ENG_WAIT} eng_state_t;

	eng_state_t state_q, state_d;
	logic req_q, req_d;
	logic [23:0] addr_q, addr_d;
	logic done_q, done_d;
	logic ok_q, ok_d;
	logic [31:0] data_q, data_d;

	// request held until the bus acknowledges
	always_comb begin
		state_d = state_q;
		req_d = req_q;
		addr_d = addr_q;
		done_d = 1'b0;
		ok_d = ok_q;
		data_d = data_q;
		case (state_q)
			ENG_IDLE: begin
				if (fx.start) begin
					req_d = 1'b1;
					addr_d = fx.addr;
					state_d = ENG_WAIT;
				end
			end
			ENG_WAIT: begin
				if (rbus_ack_i) begin
					req_d = 1'b0;
					done_d = 1'b1;
					ok_d = !rbus_err_i;
					data_d = rbus_data_i;
					state_d = ENG_IDLE;
				end
			end
			default: begin
				state_d = ENG_IDLE;
				req_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ENG_IDLE;
			req_q <= 1'b0;
			addr_q <= 24'h000000;
			done_q <= 1'b0;
			ok_q <= 1'b0;
			data_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			req_q <= req_d;
			addr_q <= addr_d;
			done_q <= done_d;
			ok_q <= ok_d;
			data_q <= data_d;
		end
	end

	assign rbus_req_o = req_q;
	assign rbus_addr_o = addr_q;
	assign fx.done = done_q;
	assign fx.data = data_q;
	assign fx.ok = ok_q;
endmodule // read_engine

// [testbench.sv]
`timescale 1ns/1ns
// ==========
// bench top
module testbench;
	import rdport_pkg::*;
	logic mclk_i = 0, reset_i = 1, ptr_load_i = 0, wr_byte_i = 0, rd_byte_i = 0, host_rd_i = 0;
	logic read_addr_increment_en_i = 0, rb_err = 0, rd_valid_o, busy_o, rbus_req_o, rbus_ack_i;
	logic rbus_err_i, host_rd_valid_o, access_ok_flag_o;
	logic [7:0] ptr_value_i = 0, wr_data_i = 0, rd_data_o, per_ptr_o;
	logic [1:0] read_access_size_i = 0;
	logic [3:0] lat = 0;
	logic [19:0] host_addr_i = 0;
	logic [23:0] rbus_addr_o;
	logic [31:0] rbus_data_i, host_rd_data_o, r, a, w;
	int error_cnt = 0, checks = 0;
	i2c_slave_internal_read_port u_dut (.mclk_i, .reset_i, .ptr_load_i, .ptr_value_i, .wr_byte_i,
		.wr_data_i, .rd_byte_i, .rd_data_o, .rd_valid_o, .busy_o, .per_ptr_o,
		.read_addr_increment_en_i, .read_access_size_i, .rbus_req_o, .rbus_addr_o, .rbus_ack_i,
		.rbus_err_i, .rbus_data_i, .host_rd_i, .host_addr_i, .host_rd_data_o, .host_rd_valid_o,
		.access_ok_flag_o);
	rbus_responder u_rsp (.mclk_i, .reset_i, .req_i(rbus_req_o), .addr_i(rbus_addr_o), .lat_i(lat),
		.err_in_i(rb_err), .ack_o(rbus_ack_i), .err_o(rbus_err_i), .data_o(rbus_data_i));
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	// ==========
	// shared tasks
	task tally_and_finish;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// kind 0 pointer, 1 write, 2 slave read, 3 host read; one cycle strobe, then one idle cycle
	task automatic op(input int k, input logic [19:0] v, output logic [31:0] q);
		int n;
		logic late;
		n = 0;
		ptr_load_i = (k == 0);
		wr_byte_i = (k == 1);
		rd_byte_i = (k == 2);
		host_rd_i = (k == 3);
		{ptr_value_i, wr_data_i} = {v[7:0], v[7:0]};
		host_addr_i = v;
		@(negedge mclk_i);
		{ptr_load_i, wr_byte_i, rd_byte_i, host_rd_i} = 4'h0;
		while (k == 2 && rd_valid_o !== 1'b1 && n < 40) begin
			@(negedge mclk_i);
			n++;
		end
		late = (k == 2 && rd_valid_o !== 1'b1);
		// answers are taken while they stand, before the idle cycle
		q = (k == 3) ? host_rd_data_o : {24'h0, rd_data_o};
		// idle cycle so no strobe is lowered and raised in one time step
		@(negedge mclk_i);
		if (late) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	function automatic logic [31:0] word_at(input logic [31:0] ad);
		return {~ad[7:0], ad[23:0]};
	endfunction
	// ==========
	// scenarios
	initial begin
		void'($urandom(32));
		repeat (20) @(negedge mclk_i);
		reset_i = 0;
		op(3, OFS_READ_ADDRESS, r);
		chk(r, READ_ADDRESS_RST);
		op(3, OFS_READ_DATA, r);
		chk(r, READ_DATA_RST);
		a = $urandom | 32'h3;
		op(0, PER_ADDR_B0, r);
		for (int i = 0; i < 4; i++)
			op(1, a[8*i +: 8], r);
		a = a & ADDR_ALIGN_MASK;
		op(3, OFS_READ_ADDRESS, r);
		chk(r, a);
		op(0, PER_DATA_B3, r);
		op(1, 20'hFF, r);
		chk(per_ptr_o, 8'h18);
		op(3, OFS_READ_DATA, r);
		chk(r, 0);
		op(0, PER_DATA_B0, r);
		// window reread as a block, zero wait last
		for (int k = 0; k < 4; k++) begin
			read_addr_increment_en_i = (k != 1);
			lat = (k == 3) ? 4'h0 : 4'($urandom_range(7));
			w = word_at(a);
			for (int i = 0; i < 4; i++) begin
				op(2, 0, r);
				chk(r, w[8*i +: 8]);
			end
			chk(per_ptr_o, PER_DATA_B0);
			if (k != 1)
				a = a + ADDR_STEP;
			op(3, OFS_READ_ADDRESS, r);
			chk(r, a);
		end
		op(3, OFS_ACC_STATUS, r);
		chk(r, 32'h80);
		op(0, PER_STAT_B0, r);
		op(2, 0, r);
		chk(r, 8'h80);
		op(0, PER_STAT_B0, r);
		op(2, 0, r);
		chk(r, 0);
		// failed fetch leaves the flag down
		{rb_err, read_addr_increment_en_i} = 2'b10;
		op(0, PER_DATA_B0, r);
		op(2, 0, r);
		op(3, OFS_ACC_STATUS, r);
		chk(r, 0);
		read_access_size_i = 2'h1;
		op(0, PER_DATA_B0, r);
		op(2, 0, r);
		chk(r, a[7:0]);
		tally_and_finish();
	end
endmodule // testbench
